/* File: pkg/dmh_pkg.sv */
// Purpose: Shared constants and carriers for the drive mode handshake block.
// Assumes: One clock domain; register addresses are the scanning register numbers.
// Notes: Upper half of each 32-bit register is sent first on the link.
package dmh_pkg;

  // Register numbers of the cyclic scanning window.
  localparam logic [15:0] DMH_ADDR_CTRL = 16'h1B0A;
  localparam logic [15:0] DMH_ADDR_REF32 = 16'h1B0C;
  localparam logic [15:0] DMH_ADDR_STATE = 16'h1B0E;
  localparam logic [15:0] DMH_ADDR_FLAGS = 16'h1B10;

  // Operating mode codes held in the low nibble of the command byte.
  localparam logic [3:0] DMH_MODE_JOG = 4'h1;
  localparam logic [3:0] DMH_MODE_HOME = 4'h2;
  localparam logic [3:0] DMH_MODE_PPOS = 4'h3;
  localparam logic [3:0] DMH_MODE_PVEL = 4'h4;
  localparam logic [3:0] DMH_MODE_SPEED = 4'h7;

  // Full command byte values, toggle bit excluded.
  localparam logic [6:0] DMH_CMD_JOG = 7'h01;
  localparam logic [6:0] DMH_CMD_HOME_SET = 7'h02;
  localparam logic [6:0] DMH_CMD_HOME_RUN = 7'h12;
  localparam logic [6:0] DMH_CMD_PP_ABS = 7'h03;
  localparam logic [6:0] DMH_CMD_PP_REL_SET = 7'h13;
  localparam logic [6:0] DMH_CMD_PP_REL_ACT = 7'h23;
  localparam logic [6:0] DMH_CMD_PVEL = 7'h04;
  localparam logic [6:0] DMH_CMD_SPEED = 7'h17;

  // Field positions.
  localparam int DMH_TOGGLE_BIT = 7;
  localparam int DMH_REJECT_BIT = 6;
  localparam int DMH_HOMED_BIT = 5;
  localparam int DMH_OPB_LSB = 16;
  localparam int DMH_SREF_LSB = 0;
  localparam int DMH_POWER_LSB = 8;
  localparam int DMH_MODE_MSB = 3;
  localparam logic [7:0] DMH_BYTE_ZERO = 8'h00;
  localparam logic [31:0] DMH_WORD_ZERO = 32'h0000_0000;
  localparam logic [15:0] DMH_HALF_ZERO = 16'h0000;
  localparam logic [3:0] DMH_NIB_ZERO = 4'h0;
  localparam logic [1:0] DMH_PAD2_ZERO = 2'h0;

  // Kinds of work handed to the motion logic.
  typedef enum logic [2:0] {
    DMH_ACT_NONE,
    DMH_ACT_JOG,
    DMH_ACT_HOME_SET,
    DMH_ACT_HOME_RUN,
    DMH_ACT_POSITION,
    DMH_ACT_VELOCITY,
    DMH_ACT_SPEED
  } dmh_act_t;

  // Register access from the fieldbus side.
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dmh_acc_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } dmh_acc_rsp_t;

  // Accepted command handed to the motion logic.
  typedef struct packed {
    logic start;
    dmh_act_t act;
    logic [3:0] mode;
    logic [15:0] short_ref;
    logic [31:0] position;
  } dmh_cmd_t;

  // Live status from the motion logic, same clock.
  typedef struct packed {
    logic [3:0] op_state;
    logic fault;
    logic warn;
    logic halt;
    logic run_extra;
    logic run_finished;
    logic run_fault;
    logic homed;
    logic busy;
    logic [31:0] actual_pos;
    logic [15:0] motion_flags;
    logic [15:0] aux_func;
  } dmh_stat_t;

endpackage

/* File: design/dmh_core.sv */
// Purpose: Cyclic scanning command interpreter with toggle handshake.
// Assumes: Register accesses and motion status share ref_clk.
// Notes: Drive input pins are asynchronous and pass a two-stage synchroniser.
// Contract
// - Low nibble of command byte selects jog, homing, position, velocity, speed.
// - Command 01h runs jog from short reference, long reference ignored.
// - 02h sets position to long reference; 12h homes with short method.
// - 03h starts absolute move, speed short, position long.
// - 13h moves relative to current target position at short speed.
// - 23h moves relative to actual motor position at short speed.
// - 17h speed control from short; 04h profile velocity from short.
// - All-zero command byte is not processed and raises no error.
// - Command fields are evaluated only when the toggle bit changed.
// - Rising and falling toggle changes are both valid.
// - Two readable 32-bit response registers carry state and flags.
// - Unit state word shows state in bits 0-3, halt in bit 8.
// - Bit 6 shows error, bit 7 shows warning.
// - Bits 13, 14, 15 show extra, finished and fault of the run.
// - Only 32-bit accesses are allowed; 16-bit access answers with error.
// - Unprocessable toggled request is rejected, flagged, running job kept.
// - Echoed toggle and reject flag returned; controller waits for them.
`timescale 1ns/100ps
`default_nettype none

module dmh_core (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire dmh_pkg::dmh_acc_req_t acc_req,
  output dmh_pkg::dmh_acc_rsp_t acc_rsp,
  input wire dmh_pkg::dmh_stat_t stat,
  input wire logic [5:0] drive_in_pins,
  output logic [7:0] power_ctrl,
  output dmh_pkg::dmh_cmd_t cmd
);
  import dmh_pkg::*;

  // Decode of the seven command bits into a kind of work.
  function automatic dmh_act_t decode_cmd(input logic [6:0] c);
    dmh_act_t a;
    a = DMH_ACT_NONE;
    case (c)
      DMH_CMD_JOG: a = DMH_ACT_JOG;
      DMH_CMD_HOME_SET: a = DMH_ACT_HOME_SET;
      DMH_CMD_HOME_RUN: a = DMH_ACT_HOME_RUN;
      DMH_CMD_PP_ABS, DMH_CMD_PP_REL_SET, DMH_CMD_PP_REL_ACT: begin
        a = DMH_ACT_POSITION;
      end
      DMH_CMD_PVEL: a = DMH_ACT_VELOCITY;
      DMH_CMD_SPEED: a = DMH_ACT_SPEED;
      default: a = DMH_ACT_NONE;
    endcase
    return a;
  endfunction

  // Field pick-outs of the control register word, shared by several processes.
  function automatic logic [7:0] op_field(input logic [31:0] w);
    return w[DMH_OPB_LSB +: 8];
  endfunction

  function automatic logic [15:0] short_field(input logic [31:0] w);
    return w[DMH_SREF_LSB +: 16];
  endfunction

  function automatic logic [15:0] ctrl_field(input logic [31:0] w);
    return w[DMH_OPB_LSB +: 16];
  endfunction

  // Positions wrap at 32 bits; the carry is dropped on purpose, not saturated.
  function automatic logic [31:0] add_ref(input logic [31:0] base, delta);
    logic [32:0] sum;
    sum = {1'b0, base} + {1'b0, delta};
    return sum[31:0];
  endfunction

  logic [15:0] drv_ctrl_q;
  logic [15:0] short_ref_q;
  logic [31:0] long_ref_q;
  logic toggle_last_q;
  logic toggle_echo_q;
  logic reject_q;
  logic [3:0] mode_q;
  logic [31:0] target_pos_q;
  logic [31:0] target_pos_d;
  logic [5:0] pins_meta_q;
  logic [5:0] pins_sync_q;
  dmh_cmd_t cmd_q;
  dmh_cmd_t cmd_d;
  dmh_acc_rsp_t rsp_q;

  logic acc_ok;
  logic ctrl_wr;
  logic [7:0] op_byte;
  logic toggled;
  logic accept;
  logic reject;
  dmh_act_t act;
  logic [15:0] unit_state_word;
  logic [7:0] run_state_byte;

  // A 16-bit access is refused outright so no half register is ever seen.
  assign acc_ok = acc_req.valid && acc_req.wide;
  assign ctrl_wr = acc_ok && acc_req.write && (acc_req.addr == DMH_ADDR_CTRL);
  assign op_byte = op_field(acc_req.wdata);

  // Any change of the toggle bit counts, in either direction.
  assign toggled = ctrl_wr
    && (op_byte[DMH_TOGGLE_BIT] != toggle_last_q);
  assign act = decode_cmd(op_byte[DMH_TOGGLE_BIT-1:0]);

  // A zero byte is silently skipped; unknown or blocked requests are refused.
  always_comb begin
    accept = 1'b0;
    reject = 1'b0;
    if (toggled && (op_byte != DMH_BYTE_ZERO)) begin
      if ((act == DMH_ACT_NONE) || stat.busy) begin
        reject = 1'b1;
      end else begin
        accept = 1'b1;
      end
    end
  end

  // Build the command from the short reference carried with the toggling write.
  // The long reference is taken from its register, loaded beforehand.
  always_comb begin
    cmd_d = '0;
    target_pos_d = target_pos_q;
    cmd_d.start = accept;
    cmd_d.act = act;
    cmd_d.mode = op_byte[DMH_MODE_MSB:0];
    cmd_d.short_ref = short_field(acc_req.wdata);
    case (op_byte[DMH_TOGGLE_BIT-1:0])
      DMH_CMD_JOG: begin
        cmd_d.position = DMH_WORD_ZERO;
      end
      DMH_CMD_HOME_SET: begin
        cmd_d.short_ref = DMH_HALF_ZERO;
        cmd_d.position = long_ref_q;
        target_pos_d = long_ref_q;
      end
      DMH_CMD_HOME_RUN: begin
        cmd_d.position = DMH_WORD_ZERO;
      end
      DMH_CMD_PP_ABS: begin
        cmd_d.position = long_ref_q;
        target_pos_d = long_ref_q;
      end
      DMH_CMD_PP_REL_SET: begin
        cmd_d.position = add_ref(target_pos_q, long_ref_q);
        target_pos_d = add_ref(target_pos_q, long_ref_q);
      end
      DMH_CMD_PP_REL_ACT: begin
        cmd_d.position = add_ref(stat.actual_pos, long_ref_q);
        target_pos_d = add_ref(stat.actual_pos, long_ref_q);
      end
      DMH_CMD_PVEL, DMH_CMD_SPEED: begin
        cmd_d.position = DMH_WORD_ZERO;
      end
      default: begin
        cmd_d.position = DMH_WORD_ZERO;
      end
    endcase
    if (!accept) begin
      target_pos_d = target_pos_q;
    end
  end

  // Control registers written by the controller.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      drv_ctrl_q <= DMH_HALF_ZERO;
      short_ref_q <= DMH_HALF_ZERO;
      long_ref_q <= DMH_WORD_ZERO;
    end else begin
      if (ctrl_wr) begin
        drv_ctrl_q <= ctrl_field(acc_req.wdata);
        short_ref_q <= short_field(acc_req.wdata);
      end
      if (acc_ok && acc_req.write && (acc_req.addr == DMH_ADDR_REF32)) begin
        long_ref_q <= acc_req.wdata;
      end
    end
  end

  // Toggle history and its echo; the echo follows every seen toggle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      toggle_last_q <= 1'b0;
      toggle_echo_q <= 1'b0;
    end else if (ctrl_wr) begin
      toggle_last_q <= op_byte[DMH_TOGGLE_BIT];
      if (toggled) begin
        toggle_echo_q <= op_byte[DMH_TOGGLE_BIT];
      end
    end
  end

  // Reject flag is held until a later toggled request is accepted.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reject_q <= 1'b0;
    end else if (reject) begin
      reject_q <= 1'b1;
    end else if (accept) begin
      reject_q <= 1'b0;
    end
  end

  // Selected mode and target tracking; a rejected request changes neither.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_q <= DMH_NIB_ZERO;
      target_pos_q <= DMH_WORD_ZERO;
    end else begin
      target_pos_q <= target_pos_d;
      if (accept) begin
        mode_q <= op_byte[DMH_MODE_MSB:0];
      end
    end
  end

  // Command pulse to the motion logic, one cycle per accepted request.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_q <= '0;
    end else if (accept) begin
      cmd_q <= cmd_d;
    end else begin
      cmd_q.start <= 1'b0;
    end
  end

  // Input pins come from outside the clock domain.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pins_meta_q <= 6'h00;
      pins_sync_q <= 6'h00;
    end else begin
      pins_meta_q <= drive_in_pins;
      pins_sync_q <= pins_meta_q;
    end
  end

  // Status words assembled from live motion state.
  always_comb begin
    unit_state_word = {
      stat.run_fault,
      stat.run_finished,
      stat.run_extra,
      DMH_NIB_ZERO,
      stat.halt,
      stat.warn,
      stat.fault,
      DMH_PAD2_ZERO,
      stat.op_state
    };
    run_state_byte = DMH_BYTE_ZERO;
    run_state_byte[DMH_TOGGLE_BIT] = toggle_echo_q;
    run_state_byte[DMH_REJECT_BIT] = reject_q;
    run_state_byte[DMH_HOMED_BIT] = stat.homed;
    run_state_byte[DMH_MODE_MSB:0] = mode_q;
  end

  // Access answer: one cycle after the request, error on bad width or address.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rsp_q <= '0;
    end else begin
      rsp_q.done <= acc_req.valid;
      rsp_q.err <= 1'b0;
      rsp_q.rdata <= DMH_WORD_ZERO;
      if (acc_req.valid && !acc_req.wide) begin
        rsp_q.err <= 1'b1;
      end else if (acc_req.valid) begin
        case (acc_req.addr)
          DMH_ADDR_CTRL: rsp_q.rdata <= {drv_ctrl_q, short_ref_q};
          DMH_ADDR_REF32: rsp_q.rdata <= long_ref_q;
          DMH_ADDR_STATE: begin
            rsp_q.err <= acc_req.write;
            rsp_q.rdata <= {unit_state_word, run_state_byte,
                            DMH_PAD2_ZERO, pins_sync_q};
          end
          DMH_ADDR_FLAGS: begin
            rsp_q.err <= acc_req.write;
            rsp_q.rdata <= {stat.motion_flags, stat.aux_func};
          end
          default: rsp_q.err <= 1'b1;
        endcase
      end
    end
  end

  // Outputs come straight from flip-flops so the far side sees no glitches.
  assign acc_rsp = rsp_q;
  assign cmd = cmd_q;
  assign power_ctrl = drv_ctrl_q[DMH_POWER_LSB +: 8];

endmodule

`default_nettype wire

/* File: bench/dmh_fieldbus_model.sv */
// Purpose: Fieldbus controller model doing cyclic scanning accesses.
// Assumes: Requests start on a falling edge; done stands the next cycle.
// Notes: Released lines carry inverted values so stale data cannot pass.
`timescale 1ns/100ps
`default_nettype none
module dmh_fieldbus_model
  import dmh_pkg::*;
(
  input wire logic ref_clk,
  output dmh_pkg::dmh_acc_req_t acc_req,
  input wire dmh_pkg::dmh_acc_rsp_t acc_rsp
);
  logic tog_q = 1'b0;
  initial acc_req = '0;

  // One access held over its taking edge; the answer is read while done stands.
  task automatic access(input logic wr, wide, input logic [15:0] a,
      input logic [31:0] d, output logic err, output logic [31:0] rd);
    @(negedge ref_clk);
    acc_req = '{1'b1, wr, wide, a, d};
    @(negedge ref_clk);
    err = acc_rsp.err;
    rd = acc_rsp.rdata;
    acc_req = '{1'b0, 1'b0, 1'b1, ~a, ~d};
  endtask

  // The long reference goes first, then the command with the short one, then the state with its echo is read back once.
  task automatic send(input logic [6:0] code, input logic flip,
      input logic [15:0] r16, input logic [31:0] r32, output logic [31:0] st);
    logic e;
    access(1'b1, 1'b1, DMH_ADDR_REF32, r32, e, st);
    tog_q = tog_q ^ flip;
    access(1'b1, 1'b1, DMH_ADDR_CTRL, {8'h00, tog_q, code, r16}, e,
      st);
    access(1'b0, 1'b1, DMH_ADDR_STATE, 32'h0, e, st);
  endtask
endmodule
`default_nettype wire

/* File: bench/dmh_core_assertions.sv */
// Purpose: Port-level checker for the command interpreter.
// Assumes: Answers are registered one cycle after each request.
// Notes: Attached to every core instance by the bind below.
`timescale 1ns/100ps
`default_nettype none
module dmh_core_assertions
  import dmh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire dmh_pkg::dmh_acc_req_t acc_req,
  input wire dmh_pkg::dmh_acc_rsp_t acc_rsp,
  input wire dmh_pkg::dmh_stat_t stat,
  input wire logic [5:0] drive_in_pins,
  input wire logic [7:0] power_ctrl,
  input wire dmh_pkg::dmh_cmd_t cmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic wr_ctrl;
  logic rd_state;

  // Decoded request kinds shared by several properties.
  assign wr_ctrl = acc_req.valid && acc_req.write && acc_req.wide &&
    acc_req.addr == DMH_ADDR_CTRL;
  assign rd_state = acc_req.valid && !acc_req.write &&
    acc_req.addr == DMH_ADDR_STATE;

  answer_latency_a: assert property (
    acc_req.valid |=> acc_rsp.done) else $error("access not answered");
  lone_done_a: assert property (
    acc_rsp.done |-> $past(acc_req.valid)) else $error("spurious done");
  narrow_refused_a: assert property (
    acc_req.valid && !acc_req.wide |=> acc_rsp.err) else $error("narrow ok");
  ro_write_a: assert property (
    acc_req.valid && acc_req.write && (acc_req.addr == DMH_ADDR_STATE ||
    acc_req.addr == DMH_ADDR_FLAGS) |=> acc_rsp.err) else $error("ro write");
  state_reserved_a: assert property (
    acc_rsp.done && !acc_rsp.err && $past(rd_state) |->
    acc_rsp.rdata[28:25] == 4'h0 && acc_rsp.rdata[21:20] == 2'h0)
    else $error("reserved bits set");
  zero_byte_a: assert property (
    wr_ctrl && acc_req.wdata[23:16] == 8'h00 |=> !cmd.start)
    else $error("zero byte started");
  start_cause_a: assert property (
    cmd.start |-> $past(wr_ctrl) && acc_rsp.done && !acc_rsp.err)
    else $error("start without command");
  busy_refused_a: assert property (
    wr_ctrl && stat.busy |=> !cmd.start) else $error("busy started");
  jog_position_a: assert property (
    cmd.start && cmd.act == DMH_ACT_JOG |-> cmd.position == 32'h0)
    else $error("jog used long reference");
endmodule

bind dmh_core dmh_core_assertions chk (.ref_clk, .rst_b, .acc_req, .acc_rsp,
  .stat, .drive_in_pins, .power_ctrl, .cmd);
`default_nettype wire

/* File: bench/dmh_core_test.sv */
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Inputs change on the falling edge of a 40 MHz clock.
// Notes: Toggle history in the model decides each command byte.
`timescale 1ns/100ps
`default_nettype none
module dmh_core_test;
  import dmh_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] pins = 6'h2D;
  dmh_stat_t stat = {4'h0, 8'h00, 32'h5000, 32'h0};
  dmh_acc_req_t acc_req;
  dmh_acc_rsp_t acc_rsp;
  dmh_cmd_t cmd;
  dmh_cmd_t got;
  logic [7:0] power_ctrl;
  int starts = 0;
  int miscompares = 0;
  int checks_done = 0;

  // Clock and device under test with its controller.
  always #12.5 ref_clk = ~ref_clk;
  dmh_core dut (.ref_clk, .rst_b, .acc_req, .acc_rsp, .stat,
    .drive_in_pins(pins), .power_ctrl, .cmd);
  dmh_fieldbus_model m (.ref_clk, .acc_req, .acc_rsp);

  // Keep every accepted command; the pulse is looked at mid-cycle, settled.
  always @(negedge ref_clk) begin
    if (cmd.start === 1'b1) begin
      got <= cmd;
      starts <= starts + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every command code with its references, toggling both ways.
  task automatic t_cmds();
    logic [6:0] c [8] = '{7'h01, 7'h02, 7'h12, 7'h03, 7'h13, 7'h23,
      7'h04, 7'h17};
    logic [15:0] s [8] = '{16'h5, 16'h0, 16'h23, 16'h300, 16'h300, 16'h200,
      16'h400, 16'h700};
    logic [31:0] l [8] = '{32'h0, 32'h1000, 32'h0, 32'h2000, 32'h100, 32'h10,
      32'h0, 32'h0};
    logic [31:0] p [8] = '{32'h0, 32'h1000, 32'h0, 32'h2000, 32'h2100,
      32'h5010, 32'h0, 32'h0};
    logic [2:0] a [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6};
    logic [31:0] st;
    int n;
    for (int i = 0; i < 8; i++) begin
      n = starts;
      m.send(c[i], 1'b1, s[i], l[i], st);
      chk(32'(starts - n), 32'h1);
      chk({got.short_ref, 9'h0, got.act, got.mode},
        {s[i], 9'h0, a[i], c[i][3:0]});
      chk(got.position, p[i]);
      chk({24'h0, st[15:8]}, {24'h0, m.tog_q, 3'h0, c[i][3:0]});
    end
  endtask

  // Bad code and busy are refused; zero byte and a repeat do nothing.
  task automatic t_refuse();
    logic [31:0] st;
    int n;
    n = starts;
    m.send(7'h05, 1'b1, 16'h0, 32'h0, st);
    chk({24'h0, st[15:8]}, {24'h0, m.tog_q, 7'h47});
    stat.busy = 1'b1;
    m.send(7'h01, 1'b1, 16'h5, 32'h0, st);
    stat.busy = 1'b0;
    chk({24'h0, st[15:8]}, {24'h0, m.tog_q, 7'h47});
    m.send(7'h04, 1'b1, 16'h400, 32'h0, st);
    chk({24'h0, st[15:8]}, {24'h0, m.tog_q, 7'h04});
    m.send(7'h00, 1'b1, 16'h0, 32'h0, st);
    chk({24'h0, st[15:8]}, 32'h04);
    m.send(7'h01, 1'b0, 16'h5, 32'h0, st);
    chk(32'(starts - n), 32'h1);
  endtask

  // Status layout, control readback, then refused accesses.
  task automatic t_regs();
    logic e;
    logic [31:0] d;
    int n;
    n = starts;
    stat = {4'h6, 8'hF4, 32'h5000, 32'h1234_00AB};
    m.access(1'b0, 1'b1, DMH_ADDR_STATE, 32'h0, e, d);
    chk(d, 32'hA1C6_042D);
    stat = {4'h9, 8'h0A, 32'h5000, 32'h1234_00AB};
    m.access(1'b0, 1'b1, DMH_ADDR_STATE, 32'h0, e, d);
    chk(d, 32'h4009_242D);
    m.access(1'b0, 1'b1, DMH_ADDR_FLAGS, 32'h0, e, d);
    chk(d, 32'h1234_00AB);
    m.access(1'b1, 1'b1, DMH_ADDR_CTRL, {8'hA5, m.tog_q, 7'h01, 16'h5},
      e, d);
    chk(32'(e), 32'h0);
    chk({24'h0, power_ctrl}, 32'hA5);
    m.access(1'b0, 1'b1, DMH_ADDR_CTRL, 32'h0, e, d);
    chk(d, {8'hA5, m.tog_q, 7'h01, 16'h5});
    chk(32'(starts - n), 32'h0);
    m.access(1'b0, 1'b0, DMH_ADDR_STATE, 32'h0, e, d);
    chk(32'(e), 32'h1);
    m.access(1'b0, 1'b1, 16'h1B12, 32'h0, e, d);
    chk(32'(e), 32'h1);
    m.access(1'b1, 1'b1, DMH_ADDR_FLAGS, 32'h0, e, d);
    chk(32'(e), 32'h1);
  endtask

  // Main sequence after two reset cycles.
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    t_cmds();
    t_refuse();
    t_regs();
    finish_test();
  end

  // The sequence needs just under a hundred cycles; far beyond that it has hung.
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
